/* File: rtl/plb_params.svh */
`ifndef PLB_PARAMS_SVH
`define PLB_PARAMS_SVH
`define PLB_ADDR_W          5
`define PLB_DATA_W          16
`define PLB_OFS_LOOP_CTRL   5'h13
`define PLB_OFS_ERR_TALLY   5'h14
`define PLB_LOOP_RESET      16'h1041
`define PLB_TALLY_RESET     16'h0000
`define PLB_TALLY_MAX       16'hFFFF
`define PLB_BIT_ALLDIG      12
`define PLB_BIT_LINEDRV     10
`define PLB_BIT_FAREND      9
`define PLB_BIT_RXSUP       8
`define PLB_BIT_CABLE       7
`define PLB_BIT_TXMUTE      6
`define PLB_BIT_LINKGOOD    0
`define PLB_RSV_RW_HI       15
`define PLB_RSV_RW_LO       13
`define PLB_BIT_RSV_RO      11
`define PLB_RSV_RO_HI       5
`define PLB_RSV_RO_LO       1
`define PLB_LOOP_WMASK      16'hF7C1
`define PLB_NIBBLE_W        4
`endif

/* File: rtl/plb_pkg.sv */
`default_nettype none
package plb_pkg;
  typedef struct packed {
    logic [3:0] data;
    logic       valid;
    logic       err;
  } plb_mii_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } plb_mgmt_req_t;
endpackage
`default_nettype wire

/* File: rtl/plb_sync2.sv */
`default_nettype none
module plb_sync2 (
  input  wire logic clk,   // Core clock
  input  wire logic rst_n, // Async reset, active low
  input  wire logic d,     // Asynchronous level
  output logic      q      // Synchronised level
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/plb_loopback_regs.sv */
`include "plb_params.svh"
`default_nettype none
module plb_loopback_regs
  import plb_pkg::*;
(
  input  wire logic          clk,                // 50 MHz core clock
  input  wire logic          rst_n,              // Async reset, active low
  input  wire plb_mgmt_req_t mgmtReq,            // One-cycle read/write
  output logic [15:0]        mgmtRdata,          // Read data, registered
  output logic               mgmtRvalid,         // Read data valid pulse
  input  wire logic          stdLoopback,        // Standard loopback bit
  input  wire logic          diagClockEnable,    // Diagnostic clock enable
  input  wire logic          linkUpRaw,          // Link up, async status
  input  wire logic          checkerErr,         // Frame checker error pulse
  input  wire plb_mii_t      macTx,              // From MAC transmit side
  input  wire plb_mii_t      adcRx,              // Receive path from ADC
  input  wire plb_mii_t      echoRx,             // Receive with echo cancel off
  output plb_mii_t           macRx,              // To MAC receive side
  output plb_mii_t           dacTx,              // To line driver path
  output logic               mediaTxEnable,      // Media transmit not muted
  output logic               echoCancelBypass,   // Keep own signal at receiver
  output logic               linkStatusGood,     // Reported link status
  output logic               allDigitalActive,   // Mode status
  output logic               lineDriverActive,   // Mode status
  output logic               farEndActive,       // Mode status
  output logic               cableLoopActive     // Mode status
);
  ////////////////////////////////////////////////////////////////////////////
  logic        rstMeta_q;
  logic        rstSync_q;
  logic        linkUp;
  logic [15:0] loopCtrl_q;
  logic [15:0] tally_q;
  logic [15:0] tally_d;
  logic        selAllDig;
  logic        selLineDrv;
  logic        selFarEnd;
  logic        selCable;
  logic        anyLoop;
  logic        countErr;
  logic        tallyRead;

  // Reset is released synchronously so no flop leaves reset mid-edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  plb_sync2 u_link_sync (
    .clk   (clk),
    .rst_n (rstSync_q),
    .d     (linkUpRaw),
    .q     (linkUp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Loop control register; only writable bits ever change
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      loopCtrl_q <= `PLB_LOOP_RESET;
    end else if (mgmtReq.wr && mgmtReq.addr == `PLB_OFS_LOOP_CTRL) begin
      loopCtrl_q <= mgmtReq.wdata & `PLB_LOOP_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign tallyRead = mgmtReq.rd && mgmtReq.addr == `PLB_OFS_ERR_TALLY;
  assign countErr  = checkerErr && diagClockEnable;

  always_comb begin
    tally_d = tally_q;
    if (tallyRead) begin
      tally_d = countErr ? 16'h0001 : `PLB_TALLY_RESET;
    end else if (countErr && tally_q != `PLB_TALLY_MAX) begin
      tally_d = tally_q + 16'h0001;
    end
  end

  // Tally ignores writes entirely
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      tally_q <= `PLB_TALLY_RESET;
    end else begin
      tally_q <= tally_d;
    end
  end

  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      mgmtRdata  <= 16'h0000;
      mgmtRvalid <= 1'b0;
    end else begin
      mgmtRvalid <= mgmtReq.rd;
      if (mgmtReq.rd) begin
        unique case (mgmtReq.addr)
          `PLB_OFS_LOOP_CTRL: mgmtRdata <= loopCtrl_q;
          `PLB_OFS_ERR_TALLY: mgmtRdata <= tally_q;
          default:            mgmtRdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode; cable loop is only honoured with standard loopback clear
  assign selAllDig  = stdLoopback && loopCtrl_q[`PLB_BIT_ALLDIG];
  assign selLineDrv = stdLoopback && !selAllDig
                      && loopCtrl_q[`PLB_BIT_LINEDRV];
  assign selFarEnd  = !stdLoopback && loopCtrl_q[`PLB_BIT_FAREND]
                      && linkUp;
  assign selCable   = !stdLoopback && !selFarEnd
                      && loopCtrl_q[`PLB_BIT_CABLE];
  assign anyLoop    = selAllDig || selLineDrv || selFarEnd || selCable;

  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      allDigitalActive <= 1'b0;
      lineDriverActive <= 1'b0;
      farEndActive     <= 1'b0;
      cableLoopActive  <= 1'b0;
      echoCancelBypass <= 1'b0;
      mediaTxEnable    <= 1'b0;
      linkStatusGood   <= 1'b0;
    end else begin
      allDigitalActive <= selAllDig;
      lineDriverActive <= selLineDrv;
      farEndActive     <= selFarEnd;
      cableLoopActive  <= selCable;
      echoCancelBypass <= selLineDrv || selCable;
      mediaTxEnable    <= !(selAllDig && loopCtrl_q[`PLB_BIT_TXMUTE]);
      linkStatusGood   <= (stdLoopback && loopCtrl_q[`PLB_BIT_LINKGOOD])
                          || linkUp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath muxes, one register stage each way
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      macRx <= '0;
      dacTx <= '0;
    end else begin
      if (anyLoop && loopCtrl_q[`PLB_BIT_RXSUP]) begin
        macRx <= '0;
      end else if (selAllDig) begin
        macRx <= macTx;
      end else if (selLineDrv || selCable) begin
        macRx <= echoRx;
      end else begin
        macRx <= adcRx;
      end
      if (selFarEnd) begin
        dacTx <= adcRx;
      end else if (selAllDig) begin
        dacTx <= macTx;
      end else begin
        dacTx <= macTx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_reset_value;
    @(posedge clk) $rose(rstSync_q) |-> loopCtrl_q == `PLB_LOOP_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("loop control reset value wrong");

  property p_alldig_needs_std;
    @(posedge clk) disable iff (!rstSync_q)
      allDigitalActive |-> $past(stdLoopback);
  endproperty
  a_alldig_needs_std: assert property (p_alldig_needs_std)
    else $error("all-digital loopback without standard loopback");

  property p_alldig_data;
    @(posedge clk) disable iff (!rstSync_q)
      (selAllDig && !loopCtrl_q[`PLB_BIT_RXSUP]) |=> macRx == $past(macTx);
  endproperty
  a_alldig_data: assert property (p_alldig_data)
    else $error("all-digital loopback data not returned");

  property p_rx_suppress;
    @(posedge clk) disable iff (!rstSync_q)
      (anyLoop && loopCtrl_q[`PLB_BIT_RXSUP]) |=> macRx == '0;
  endproperty
  a_rx_suppress: assert property (p_rx_suppress)
    else $error("data reached MAC while suppressed");

  property p_tx_mute;
    @(posedge clk) disable iff (!rstSync_q)
      (selAllDig && loopCtrl_q[`PLB_BIT_TXMUTE]) |=> !mediaTxEnable;
  endproperty
  a_tx_mute: assert property (p_tx_mute)
    else $error("transmit not muted in all-digital loopback");

  property p_far_end_link;
    @(posedge clk) disable iff (!rstSync_q)
      farEndActive |-> $past(linkUp);
  endproperty
  a_far_end_link: assert property (p_far_end_link)
    else $error("remote loopback without link");

  property p_ro_bits_zero;
    @(posedge clk) disable iff (!rstSync_q)
      loopCtrl_q[`PLB_BIT_RSV_RO] == 1'b0
      && loopCtrl_q[`PLB_RSV_RO_HI:`PLB_RSV_RO_LO] == 5'h00;
  endproperty
  a_ro_bits_zero: assert property (p_ro_bits_zero)
    else $error("read-only bits not zero");

  sequence s_tally_read;
    tallyRead && !countErr;
  endsequence
  property p_read_clears;
    @(posedge clk) disable iff (!rstSync_q)
      s_tally_read |=> tally_q == `PLB_TALLY_RESET;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("tally not cleared by read");

  property p_saturate;
    @(posedge clk) disable iff (!rstSync_q)
      (tally_q == `PLB_TALLY_MAX && !tallyRead) |=> tally_q == `PLB_TALLY_MAX;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("tally wrapped");

  property p_diag_gate;
    @(posedge clk) disable iff (!rstSync_q)
      (!diagClockEnable && !tallyRead) |=> $stable(tally_q);
  endproperty
  a_diag_gate: assert property (p_diag_gate)
    else $error("tally counted with diagnostic clock off");

  property p_link_force;
    @(posedge clk) disable iff (!rstSync_q)
      (stdLoopback && loopCtrl_q[`PLB_BIT_LINKGOOD]) |=> linkStatusGood;
  endproperty
  a_link_force: assert property (p_link_force)
    else $error("link not forced good in loopback");

  property p_alldig_select;
    @(posedge clk) disable iff (!rstSync_q)
      (stdLoopback && loopCtrl_q[`PLB_BIT_ALLDIG]) |=> allDigitalActive;
  endproperty
  a_alldig_select: assert property (p_alldig_select)
    else $error("all-digital loopback not selected");

  property p_line_drv_enter;
    @(posedge clk) disable iff (!rstSync_q)
      (stdLoopback && loopCtrl_q[`PLB_BIT_LINEDRV]
       && !loopCtrl_q[`PLB_BIT_ALLDIG]) |=> lineDriverActive;
  endproperty
  a_line_drv_enter: assert property (p_line_drv_enter)
    else $error("line driver loopback not entered");

  // Reflected signal reaches the MAC through the uncancelled receive path
  property p_line_drv_data;
    @(posedge clk) disable iff (!rstSync_q)
      (selLineDrv && !loopCtrl_q[`PLB_BIT_RXSUP]) |=> macRx == $past(echoRx);
  endproperty
  a_line_drv_data: assert property (p_line_drv_data)
    else $error("line driver loopback data not returned");

  property p_cable_data;
    @(posedge clk) disable iff (!rstSync_q)
      (selCable && !loopCtrl_q[`PLB_BIT_RXSUP]) |=> macRx == $past(echoRx);
  endproperty
  a_cable_data: assert property (p_cable_data)
    else $error("cable loopback data not returned");

  property p_echo_bypass;
    @(posedge clk) disable iff (!rstSync_q)
      (selLineDrv || selCable) |=> echoCancelBypass;
  endproperty
  a_echo_bypass: assert property (p_echo_bypass)
    else $error("own signal cancelled in loopback");

  property p_far_end_data;
    @(posedge clk) disable iff (!rstSync_q)
      selFarEnd |=> dacTx == $past(adcRx);
  endproperty
  a_far_end_data: assert property (p_far_end_data)
    else $error("remote loopback data not sent back");

  property p_cable_std_clear;
    @(posedge clk) disable iff (!rstSync_q)
      cableLoopActive |-> !$past(stdLoopback);
  endproperty
  a_cable_std_clear: assert property (p_cable_std_clear)
    else $error("cable loopback with standard loopback set");

  sequence s_read_with_err;
    tallyRead && countErr;
  endsequence
  property p_read_keeps_inc;
    @(posedge clk) disable iff (!rstSync_q)
      s_read_with_err |=> tally_q == 16'h0001;
  endproperty
  a_read_keeps_inc: assert property (p_read_keeps_inc)
    else $error("increment lost on read");

  property p_tally_count;
    @(posedge clk) disable iff (!rstSync_q)
      (countErr && !tallyRead && tally_q != `PLB_TALLY_MAX)
      |=> tally_q == $past(tally_q) + 16'h0001;
  endproperty
  a_tally_count: assert property (p_tally_count)
    else $error("error not counted");

  property p_read_data;
    @(posedge clk) disable iff (!rstSync_q)
      tallyRead |=> mgmtRvalid && mgmtRdata == $past(tally_q);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("tally read data wrong");

  property p_write_ignored;
    @(posedge clk) disable iff (!rstSync_q)
      (mgmtReq.wr && mgmtReq.addr != `PLB_OFS_LOOP_CTRL)
      |=> $stable(loopCtrl_q);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("foreign write changed loop control");

  property p_rw_echo;
    @(posedge clk) disable iff (!rstSync_q)
      (mgmtReq.wr && mgmtReq.addr == `PLB_OFS_LOOP_CTRL)
      |=> loopCtrl_q == ($past(mgmtReq.wdata) & `PLB_LOOP_WMASK);
  endproperty
  a_rw_echo: assert property (p_rw_echo)
    else $error("loop control write not kept");
endmodule
`default_nettype wire

/* File: dv/plb_mgmt_host.sv */
`default_nettype none
// Station management host: issues one-cycle register requests
module plb_mgmt_host
  import plb_pkg::*;
(
  input  wire logic        clk,        // Core clock
  output plb_mgmt_req_t    mgmtReq,    // Request to the register bank
  input  wire logic [15:0] mgmtRdata,  // Read data
  input  wire logic        mgmtRvalid  // Read data valid pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  initial mgmtReq = '0;
  // Idle data is inverted so a stale value never reads as a match
  task automatic writeReg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmtReq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    mgmtReq <= '{rd: 1'b0, wr: 1'b0, addr: a, wdata: ~d};
  endtask
  // Read valid stands one cycle only, so it is taken just after the edge
  task automatic readReg(input logic [4:0] a, output logic [15:0] d,
                         output logic v);
    @(posedge clk);
    mgmtReq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk);
    mgmtReq <= '{rd: 1'b0, wr: 1'b0, addr: a, wdata: 16'hFFFF};
    #1;
    v = mgmtRvalid;
    d = mgmtRdata;
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin nFail++; \
  $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import plb_pkg::*;
  logic          clk, rst_n, stdLoopback, diagClockEnable;
  logic          linkUpRaw, checkerErr;
  plb_mgmt_req_t mgmtReq;
  plb_mii_t      macTx, adcRx, echoRx, macRx, dacTx;
  logic [15:0]   mgmtRdata;
  logic          mgmtRvalid, mediaTxEnable, echoCancelBypass;
  logic          linkStatusGood, allDigitalActive, lineDriverActive;
  logic          farEndActive, cableLoopActive;
  int            nFail, cmpCount, cycles;
  plb_loopback_regs i_plb_loopback_regs (.clk, .rst_n, .mgmtReq,
    .mgmtRdata, .mgmtRvalid, .stdLoopback, .diagClockEnable, .linkUpRaw,
    .checkerErr, .macTx, .adcRx, .echoRx, .macRx, .dacTx, .mediaTxEnable,
    .echoCancelBypass, .linkStatusGood, .allDigitalActive,
    .lineDriverActive, .farEndActive, .cableLoopActive);
  plb_mgmt_host i_plb_mgmt_host (.clk, .mgmtReq, .mgmtRdata, .mgmtRvalid);
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Longest test is the saturation run of about 65.5k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      nFail++;
      endSim();
    end
  end
  task automatic endSim();
    $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    i_plb_mgmt_host.readReg(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      checkerErr <= 1'b1;
      @(posedge clk);
      checkerErr <= 1'b0;
    end
  endtask
  // Mode outputs settle two cycles after the write, link path two more
  task automatic mode(input logic [15:0] w, input logic s, input logic l);
    i_plb_mgmt_host.writeReg(5'h13, w);
    stdLoopback <= s;
    linkUpRaw   <= l;
    repeat (6) @(posedge clk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    stdLoopback = 1'b0;
    diagClockEnable = 1'b0;
    linkUpRaw = 1'b0;
    checkerErr = 1'b0;
    macTx = '{data: 4'hA, valid: 1'b1, err: 1'b0};
    adcRx = '{data: 4'h5, valid: 1'b1, err: 1'b1};
    echoRx = '{data: 4'h3, valid: 1'b1, err: 1'b0};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(5'h13, 16'h1041);
    rchk(5'h14, 16'h0000);
    i_plb_mgmt_host.writeReg(5'h13, 16'hFFFF);
    rchk(5'h13, 16'hF7C1);
    i_plb_mgmt_host.writeReg(5'h13, 16'h0000);
    rchk(5'h13, 16'h0000);
    i_plb_mgmt_host.writeReg(5'h14, 16'h1234);
    rchk(5'h14, 16'h0000);
    rchk(5'h05, 16'h0000);
    $display("test registers done");
    pulses(3);
    rchk(5'h14, 16'h0000);
    @(posedge clk);
    diagClockEnable <= 1'b1;
    pulses(3);
    rchk(5'h14, 16'h0003);
    rchk(5'h14, 16'h0000);
    fork
      rchk(5'h14, 16'h0000);
      pulses(1);
    join
    rchk(5'h14, 16'h0001);
    @(posedge clk);
    checkerErr <= 1'b1;
    repeat (65540) @(posedge clk);
    checkerErr <= 1'b0;
    rchk(5'h14, 16'hFFFF);
    $display("test tally done");
    mode(16'h1041, 1'b1, 1'b0);
    `CHK(allDigitalActive, 1'b1)
    `CHK(macRx, macTx)
    `CHK(mediaTxEnable, 1'b0)
    `CHK(linkStatusGood, 1'b1)
    mode(16'h1000, 1'b1, 1'b0);
    `CHK(mediaTxEnable, 1'b1)
    `CHK(linkStatusGood, 1'b0)
    mode(16'h1141, 1'b1, 1'b0);
    `CHK(macRx, 6'h00)
    mode(16'h1041, 1'b0, 1'b0);
    `CHK(allDigitalActive, 1'b0)
    mode(16'h0400, 1'b1, 1'b0);
    `CHK(lineDriverActive, 1'b1)
    `CHK(macRx, echoRx)
    `CHK(echoCancelBypass, 1'b1)
    mode(16'h0200, 1'b0, 1'b0);
    `CHK(farEndActive, 1'b0)
    mode(16'h0200, 1'b0, 1'b1);
    `CHK(farEndActive, 1'b1)
    `CHK(dacTx, adcRx)
    // Standard loopback stays clear while the cable loop is used
    mode(16'h0080, 1'b0, 1'b0);
    `CHK(cableLoopActive, 1'b1)
    `CHK(echoCancelBypass, 1'b1)
    `CHK(macRx, echoRx)
    $display("test modes done");
    // Reset in mid-run must restore both registers
    pulses(2);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(5'h13, 16'h1041);
    rchk(5'h14, 16'h0000);
    $display("test reset done");
    endSim();
  end
endmodule
`default_nettype wire
